// File: dfc_transfer_engine.sv
//
// Purpose: four channel flyby transfer_engine on the processor bus
// Assumes: requests, grant and halt come from logic on core_clk
// Notes:   data never passes through this block; only strobes and address
//
// Behaviour
// R1: requests come only from peripherals or software
// R2: win bus mastership before any transfer cycle
// R3: resolve priority one clock before first_bus_clock
// R4: fixed priority, channel 0 highest
// R5: acknowledge during the cycle touching requester
// R6: block end: flags, interrupt, then release bus; here bus_request drops with the flags, a clock before channel_irq
// R7: continuous with request held: keep bus, transfer
// R8: sample next request as acknowledge drops
// R9: address step configurable independently per channel
// R10: four channels, zero to three
// R11: software enables one request source per channel
// R12: source wiring per channel, primary and secondary; channel 1 has no secondary source here
// R13: software picks indirect mode where flyby unfit; only flyby is built here
// R14: one bus cycle per item, no latching
// R15: flyby needs an implied I/O party
// R16: intermittent releases every cycle; continuous holds
// R17: peak three clocks or one clock per item
// R18: bus address from device a counter
// R19: direction bit picks read or write
// R20: width select picks byte or 16-bit items
// R21: length minus one, address stepped per item
// R22: zero length: stop, set flags, clear active
// R23: halt pauses all activity, resumes after; here the register port and channel_irq keep working during halt
// R24: level request and grant exchange with arbiter
//
`timescale 1ns/10ps
`include "dfc_defines.svh"

module dfc_transfer_engine #(
    parameter int NUM_CH = 4,           // channel count
    parameter int ADDR_W = 24,          // bus address width
    parameter int LEN_W  = 16,          // block length width
    parameter int REG_AW = 7            // register port address width
)(
    input  wire logic                core_clk,            // system clock
    input  wire logic                reset,               // synchronous, active high
    input  wire logic [REG_AW-1:0]   reg_addr,            // register byte offset
    input  wire logic [31:0]         reg_wdata,           // register write data
    input  wire logic                reg_wr,              // write strobe
    input  wire logic                reg_rd,              // read strobe
    output logic      [31:0]         reg_rdata,           // read data, one cycle later
    input  wire logic [NUM_CH-1:0]   req_primary,         // primary channel_request_line
    input  wire logic [NUM_CH-1:0]   req_secondary,       // secondary channel_request_line
    output logic      [NUM_CH-1:0]   ack_primary,         // acknowledge to primary source
    output logic      [NUM_CH-1:0]   ack_secondary,       // acknowledge to secondary source
    output logic                     bus_request,         // mastership request, level
    input  wire logic                bus_grant,           // mastership grant, level
    output logic      [ADDR_W-1:0]   bus_addr,            // addressed device address
    output logic                     bus_read,            // read cycle of addressed device
    output logic                     bus_write,           // write cycle of addressed device
    output logic                     bus_word,            // 1 = 16-bit item, 0 = byte
    input  wire logic                debug_halt,          // freezes sequencer and bus cycles; register port still works
    output logic      [NUM_CH-1:0]   channel_irq          // per channel interrupt, level
);
    import dfc_pkg::*;

    // ********************************************************
    // elaboration checks
    // ********************************************************
    initial
    begin
        if (NUM_CH != 4)                                               // R10
            $error("dfc_transfer_engine: exactly four channels are wired");
        if (ADDR_W < 2 || ADDR_W > 32 || LEN_W < 1 || LEN_W > 32)
            $error("dfc_transfer_engine: address or length width unsupported");
        if (REG_AW != `DFC_CH_SHIFT + 2)
            $error("dfc_transfer_engine: register address width must be seven");
    end

    // ********************************************************
    // channel registers
    // ********************************************************
    logic [ADDR_W-1:0]    addr_a_reg  [NUM_CH];   // device_a_address_counter
    logic [LEN_W-1:0]     length_reg  [NUM_CH];   // block_length_counter
    logic [`DFC_CTL_W-1:0] control_reg [NUM_CH];  // channel_control_register
    logic [NUM_CH-1:0]    tc_reg;                 // terminal_count_flag
    logic [NUM_CH-1:0]    ovr_reg;                // overrun_flag
    logic [NUM_CH-1:0]    active_reg;             // channel_active_flag

    // ********************************************************
    // engine state
    // ********************************************************
    dfc_state_type        state_reg;              // sequencer state
    logic [1:0]           chan_reg;               // channel being served
    logic [NUM_CH-1:0]    chan_req;               // effective request per channel
    logic [NUM_CH-1:0]    pending;                // enabled, active and requesting
    logic [1:0]           winner;                 // highest priority pending channel
    logic                 item_now;               // item moves this cycle
    logic                 last_item;              // this item empties the block
    logic [ADDR_W-1:0]    addr_step_next;         // stepped address of served channel
    logic [ADDR_W-1:0]    addr_issue;             // address for the next bus cycle
    logic [LEN_W-1:0]     length_dec;             // decremented length of served channel
    logic [1:0]           wr_ch;                  // channel addressed by register port
    logic [4:0]           wr_ofs;                 // offset within channel block

    assign wr_ch  = reg_addr[REG_AW-1:`DFC_CH_SHIFT];
    assign wr_ofs = reg_addr[`DFC_CH_SHIFT-1:0];

    // ********************************************************
    // request sources and pending set
    // ********************************************************
    // only peripheral sources or software raise a request
    generate
        for (genvar i = 0; i < NUM_CH; i++)
        begin : g_req
            logic sec_line;   // secondary source, channel 1 has none
            assign sec_line = (i == 1) ? 1'b0 : req_secondary[i];   // R12
            assign chan_req[i] = control_reg[i][`DFC_CTL_SWREQ] |
                                 (control_reg[i][`DFC_CTL_SRC_SEC] ? sec_line
                                                                    : req_primary[i]); // R1
            assign pending[i]  = chan_req[i] & control_reg[i][`DFC_CTL_ENABLE]
                                 & active_reg[i];
        end
    endgenerate

    // fixed descending priority, lowest index wins
    always_comb
    begin
        winner = 2'd3;
        for (int k = NUM_CH - 1; k >= 0; k--)
        begin
            if (pending[k])
                winner = 2'(k);   // R4
        end
    end

    // ********************************************************
    // served channel arithmetic
    // ********************************************************
    // step is one for byte items, two for word items
    always_comb
    begin
        logic [ADDR_W-1:0] step;
        step = control_reg[chan_reg][`DFC_CTL_WIDTH] ? ADDR_W'(2) : ADDR_W'(1);
        if (!control_reg[chan_reg][`DFC_CTL_STEP_EN])
            addr_step_next = addr_a_reg[chan_reg];                    // R9
        else if (control_reg[chan_reg][`DFC_CTL_STEP_DN])
            addr_step_next = addr_a_reg[chan_reg] - step;             // R21
        else
            addr_step_next = addr_a_reg[chan_reg] + step;             // R21
    end

    assign item_now   = (state_reg == DFC_XFER) && !debug_halt;         // R23
    assign length_dec = length_reg[chan_reg] - LEN_W'(1);             // R21
    assign last_item  = (length_dec == '0);

    // continuous back to back cycles use the stepped address
    assign addr_issue = (state_reg == DFC_XFER) ? addr_step_next : addr_a_reg[winner];

    // ********************************************************
    // per channel registers
    // ********************************************************
    generate
        for (genvar i = 0; i < NUM_CH; i++)
        begin : g_ch
            logic wr_hit;   // register write to this channel
            logic served;   // this channel moves an item now
            assign wr_hit = reg_wr && (wr_ch == 2'(i));
            assign served = item_now && (chan_reg == 2'(i));

            // address counter, software write wins
            always_ff @(posedge core_clk)
            begin
                if (reset)
                    addr_a_reg[i] <= '0;
                else if (wr_hit && wr_ofs == `DFC_OFS_ADDR_A)
                    addr_a_reg[i] <= reg_wdata[ADDR_W-1:0];
                else if (served)
                    addr_a_reg[i] <= addr_step_next;                  // R21
            end

            // block length counter, one per item
            always_ff @(posedge core_clk)
            begin
                if (reset)
                    length_reg[i] <= '0;
                else if (wr_hit && wr_ofs == `DFC_OFS_LENGTH)
                    length_reg[i] <= reg_wdata[LEN_W-1:0];
                else if (served)
                    length_reg[i] <= length_dec;                      // R21
            end

            // control register, software only
            always_ff @(posedge core_clk)
            begin
                if (reset)
                    control_reg[i] <= `DFC_CTL_RESET;
                else if (wr_hit && wr_ofs == `DFC_OFS_CONTROL)
                    control_reg[i] <= reg_wdata[`DFC_CTL_W-1:0];
            end

            // active flag: set on enable, cleared at block end
            always_ff @(posedge core_clk)
            begin
                if (reset)
                    active_reg[i] <= 1'b0;
                else if (served && last_item)
                    active_reg[i] <= 1'b0;                            // R22
                else if (wr_hit && wr_ofs == `DFC_OFS_CONTROL)
                    active_reg[i] <= reg_wdata[`DFC_CTL_ENABLE] && length_reg[i] != '0;
            end

            // terminal and overrun flags, write one clears, set wins
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    tc_reg[i]  <= 1'b0;
                    ovr_reg[i] <= 1'b0;
                end
                else if (served && last_item)
                begin
                    tc_reg[i]  <= 1'b1;                               // R22
                    ovr_reg[i] <= 1'b1;                               // R22
                end
                else if (wr_hit && wr_ofs == `DFC_OFS_STATUS)
                begin
                    tc_reg[i]  <= tc_reg[i] & ~reg_wdata[`DFC_ST_TC];
                    ovr_reg[i] <= ovr_reg[i] & ~reg_wdata[`DFC_ST_OVR];
                end
            end

            // interrupt level from flags and enables
            always_ff @(posedge core_clk)
            begin
                if (reset)
                    channel_irq[i] <= 1'b0;
                else
                    channel_irq[i] <= (tc_reg[i] & control_reg[i][`DFC_CTL_IE_TC]) |
                                      (ovr_reg[i] & control_reg[i][`DFC_CTL_IE_OVR]); // R6
            end
        end
    endgenerate

    // ********************************************************
    // sequencer
    // ********************************************************
    // a halted engine holds its state and drives no cycle
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_reg <= DFC_IDLE;
            chan_reg  <= 2'd0;
        end
        else if (!debug_halt)                                          // R23
        begin
            unique case (state_reg)
                DFC_IDLE:
                    if (|pending)
                        state_reg <= DFC_ARB;                          // R2
                DFC_ARB:
                    if (bus_grant)
                        state_reg <= DFC_PRIO;                         // R24
                DFC_PRIO:
                    if (!bus_grant)
                        state_reg <= DFC_ARB;                          // R24
                    else if (|pending)
                    begin
                        chan_reg  <= winner;                           // R3
                        state_reg <= DFC_XFER;
                    end
                    else
                        state_reg <= DFC_IDLE;
                DFC_XFER:
                    if (last_item)
                        state_reg <= DFC_DONE;                         // R6
                    else if (control_reg[chan_reg][`DFC_CTL_CONT] && chan_req[chan_reg])
                        state_reg <= DFC_XFER;                         // R7
                    else
                        state_reg <= DFC_IDLE;                         // R16
                DFC_DONE:
                    state_reg <= DFC_IDLE;                             // R6
            endcase
        end
    end

    // ********************************************************
    // bus mastership request
    // ********************************************************
    // held from arbitration until the last cycle ends
    always_ff @(posedge core_clk)
    begin
        if (reset)
            bus_request <= 1'b0;
        else if (debug_halt)
            bus_request <= bus_request;
        else if (state_reg == DFC_IDLE)
            bus_request <= |pending;                                   // R2
        else if (state_reg == DFC_PRIO && bus_grant && !(|pending))
            bus_request <= 1'b0;
        else if (state_reg == DFC_XFER)
            bus_request <= !last_item && control_reg[chan_reg][`DFC_CTL_CONT]
                           && chan_req[chan_reg];                      // R16
        else if (state_reg == DFC_DONE)
            bus_request <= 1'b0;                                       // R6
    end

    // ********************************************************
    // bus cycle strobes, registered into the cycle
    // ********************************************************
    logic issue;        // a bus cycle is driven next cycle
    logic [1:0] ich;    // channel of that cycle
    always_comb
    begin
        issue = 1'b0;
        ich   = winner;
        if (!debug_halt && state_reg == DFC_PRIO && bus_grant && |pending)
            issue = 1'b1;                                              // R2
        else if (!debug_halt && state_reg == DFC_XFER && !last_item &&
                 control_reg[chan_reg][`DFC_CTL_CONT] && chan_req[chan_reg])   // R8
        begin
            issue = 1'b1;                                              // R17
            ich   = chan_reg;
        end
    end

    // one bus cycle per item, no data held here
    always_ff @(posedge core_clk)                                      // R14
    begin
        if (reset)
        begin
            bus_addr      <= '0;
            bus_read      <= 1'b0;
            bus_write     <= 1'b0;
            bus_word      <= 1'b0;
            ack_primary   <= '0;
            ack_secondary <= '0;
        end
        else
        begin
            bus_addr      <= issue ? addr_issue : bus_addr;            // R18
            bus_read      <= issue && !control_reg[ich][`DFC_CTL_DIR]; // R19
            bus_write     <= issue && control_reg[ich][`DFC_CTL_DIR];  // R19
            bus_word      <= issue ? control_reg[ich][`DFC_CTL_WIDTH] : bus_word; // R20
            for (int k = 0; k < NUM_CH; k++)                           // R15
            begin
                ack_primary[k]   <= issue && ich == 2'(k) && !control_reg[k][`DFC_CTL_SWREQ]
                                    && !control_reg[k][`DFC_CTL_SRC_SEC];           // R5
                ack_secondary[k] <= issue && ich == 2'(k) && k != 1
                                    && !control_reg[k][`DFC_CTL_SWREQ]
                                    && control_reg[k][`DFC_CTL_SRC_SEC];            // R5
            end
        end
    end

    // ********************************************************
    // register read port
    // ********************************************************
    // read data stands in the cycle after the strobe only
    always_ff @(posedge core_clk)
    begin
        if (reset || !reg_rd)
            reg_rdata <= '0;
        else
        begin
            unique case (wr_ofs)
                `DFC_OFS_ADDR_A:  reg_rdata <= 32'(addr_a_reg[wr_ch]);
                `DFC_OFS_LENGTH:  reg_rdata <= 32'(length_reg[wr_ch]);
                `DFC_OFS_CONTROL: reg_rdata <= 32'(control_reg[wr_ch]);
                `DFC_OFS_STATUS:  reg_rdata <= 32'({active_reg[wr_ch], ovr_reg[wr_ch],
                                                    tc_reg[wr_ch]});
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : dfc_transfer_engine

// File: dfc_defines.svh
//
// Purpose: offsets, field positions, reset values and widths of the flyby transfer engine
// Assumes: register port with byte offsets, 32-bit read data
// Notes:   definitions only
//
`ifndef DFC_DEFINES_SVH
`define DFC_DEFINES_SVH

// ************************************************************
// register map, per channel block of 32 bytes
// ************************************************************
`define DFC_CH_SHIFT      5          // channel index sits above this bit
`define DFC_OFS_ADDR_A    5'h00      // device a address counter
`define DFC_OFS_LENGTH    5'h10      // block length counter
`define DFC_OFS_CONTROL   5'h18      // channel control register
`define DFC_OFS_STATUS    5'h1c      // channel status register

// ************************************************************
// control register fields
// ************************************************************
`define DFC_CTL_ENABLE    0          // channel enable
`define DFC_CTL_SWREQ     1          // software transfer request
`define DFC_CTL_DIR       2          // 0 read addressed, 1 write addressed
`define DFC_CTL_WIDTH     3          // transfer_width_select, 1 = 16 bit
`define DFC_CTL_STEP_EN   4          // addr_a_step_enable
`define DFC_CTL_STEP_DN   5          // addr_a_step_sense, 1 = decrement
`define DFC_CTL_CONT      6          // bus policy, 1 = continuous
`define DFC_CTL_SRC_SEC   7          // 1 = secondary request source
`define DFC_CTL_IE_TC     8          // interrupt enable, terminal count
`define DFC_CTL_IE_OVR    9          // interrupt enable, overrun
`define DFC_CTL_W         10         // implemented control width
`define DFC_CTL_RESET     10'h000    // control value after reset

// ************************************************************
// status register fields
// ************************************************************
`define DFC_ST_TC         0          // terminal_count_flag
`define DFC_ST_OVR        1          // overrun_flag
`define DFC_ST_ACT        2          // channel_active_flag

`endif

// File: dfc_pkg.sv
//
// Purpose: shared types of the flyby transfer engine
// Assumes: nothing
// Notes:   state codes are one-hot
//
package dfc_pkg;

    // ********************************************************
    // engine sequencer states
    // ********************************************************
    typedef enum logic [4:0]
    {
        DFC_IDLE = 5'h01,   // bus with the processor
        DFC_ARB  = 5'h02,   // bus request raised, waiting grant
        DFC_PRIO = 5'h04,   // resolve winning channel
        DFC_XFER = 5'h08,   // bus cycle on the bus
        DFC_DONE = 5'h10    // block ended, flags set
    } dfc_state_type;

endpackage : dfc_pkg

// File: dfc_monitor.sv
// Purpose: port checker of the flyby transfer engine
// Assumes: one clock, synchronous active high reset
// Notes:   bound at the foot of this file
`timescale 1ns/10ps

module dfc_monitor #(
    parameter int NUM_CH = 4              // channel count
)(
    input wire logic              core_clk,
    input wire logic              reset,
    input wire logic [NUM_CH-1:0] ack_primary,
    input wire logic [NUM_CH-1:0] ack_secondary,
    input wire logic              bus_request,
    input wire logic              bus_grant,
    input wire logic              bus_read,
    input wire logic              bus_write,
    input wire logic              debug_halt
);
    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    wire strobe = bus_read | bus_write;   // any item cycle

    grant_before_cycle_a: assert property (strobe |-> bus_grant && bus_request)
        else $error("bus cycle without mastership");
    prio_lead_time_a: assert property ($rose(strobe) |-> $past(bus_request, 2))
        else $error("first cycle too soon after bus request");
    one_direction_a: assert property (strobe |-> bus_read != bus_write)
        else $error("read and write strobes together");
    ack_in_cycle_a: assert property (|{ack_primary, ack_secondary} |-> strobe)
        else $error("acknowledge outside a bus cycle");
    single_winner_a: assert property ($onehot0({ack_primary, ack_secondary}))
        else $error("more than one acknowledge");
    unused_source_a: assert property (!ack_secondary[1])
        else $error("acknowledge to missing source");
    halt_freezes_a: assert property (debug_halt |=> !strobe)
        else $error("bus cycle while halted");
    release_after_item_a: assert property ($fell(bus_request) |-> $past(strobe) || $past(strobe, 2))
        else $error("bus released without an item");

    cover property (strobe ##1 strobe ##1 strobe);
    cover property ($rose(bus_request) ##[1:20] strobe);
    cover property (debug_halt && bus_request);
endmodule : dfc_monitor

bind dfc_transfer_engine dfc_monitor #(.NUM_CH(NUM_CH)) i_dfc_monitor (
    .core_clk(core_clk), .reset(reset), .ack_primary(ack_primary),
    .ack_secondary(ack_secondary), .bus_request(bus_request), .bus_grant(bus_grant),
    .bus_read(bus_read), .bus_write(bus_write), .debug_halt(debug_halt));

// File: dfc_arbiter_model.sv
// Purpose: processor bus arbiter seen by the engine
// Assumes: level request and grant on core_clk
// Notes:   grant_delay sets how many cycles the processor holds the bus
`timescale 1ns/10ps

module dfc_arbiter_model (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       bus_request,
    input wire logic [3:0] grant_delay,
    output logic           bus_grant
);
    logic [3:0] wait_reg;                 // cycles the request has waited

    // grant after the delay, withdraw as soon as request drops
    always_ff @(posedge core_clk)
    begin
        if (reset || !bus_request)
        begin
            wait_reg  <= 4'h0;
            bus_grant <= 1'b0;
        end
        else
        begin
            bus_grant <= (wait_reg >= grant_delay);
            wait_reg  <= wait_reg + {3'h0, wait_reg != 4'hf};
        end
    end
endmodule : dfc_arbiter_model

// File: tb_dfc_transfer_engine.sv
// Purpose: register and transfer tests of the flyby engine
// Assumes: arbiter model, peripheral requests driven here
// Notes: only flyby setups, one source per channel
`timescale 1ns/10ps
`include "dfc_defines.svh"

module tb_dfc_transfer_engine;
    logic        core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, debug_halt = 1'b0;
    logic [6:0]  reg_addr = 7'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [3:0]  req_primary = 4'h0, req_secondary = 4'h0, grant_delay = 4'h0;
    logic [3:0]  ack_primary, ack_secondary, channel_irq;
    logic        bus_request, bus_grant, bus_read, bus_write, bus_word;
    logic [23:0] bus_addr;
    int          miscompares = 0, checks_done = 0, cycles = 0, gap;

    dfc_transfer_engine i_dfc_transfer_engine (.core_clk(core_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .req_primary(req_primary), .req_secondary(req_secondary),
        .ack_primary(ack_primary), .ack_secondary(ack_secondary), .bus_request(bus_request),
        .bus_grant(bus_grant), .bus_addr(bus_addr), .bus_read(bus_read),
        .bus_write(bus_write), .bus_word(bus_word), .debug_halt(debug_halt),
        .channel_irq(channel_irq));
    dfc_arbiter_model i_dfc_arbiter_model (.core_clk(core_clk), .reset(reset),
        .bus_request(bus_request), .grant_delay(grant_delay), .bus_grant(bus_grant));

    always #4 core_clk = ~core_clk;

    // hang guard
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [1:0] ch, input logic [4:0] ofs, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= {ch, ofs};
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [1:0] ch, input logic [4:0] ofs, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= {ch, ofs};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(40'(reg_rdata), 40'(e));
    endtask : reg_check

    task automatic setup(input logic [1:0] ch, input logic [23:0] a, input logic [15:0] n,
                         input logic [31:0] ctl);
        reg_write(ch, `DFC_OFS_ADDR_A, 32'(a));
        reg_write(ch, `DFC_OFS_LENGTH, 32'(n));
        reg_write(ch, `DFC_OFS_CONTROL, ctl);
    endtask : setup

    // wait for the next item cycle, compare address, strobes, width, acks
    task automatic item(input logic [23:0] a, input logic rd, input logic wd,
                        input logic [7:0] ak);
        gap = 0;
        do
        begin
            @(negedge core_clk);
            gap++;
        end
        while (!(bus_read || bus_write) && gap < 60);
        chk({5'h0, bus_addr, bus_read, bus_write, bus_word, ack_secondary, ack_primary},
            {5'h0, a, rd, !rd, wd, ak});
    endtask : item

    initial
    begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        reg_check(2'd1, `DFC_OFS_STATUS, 32'h0);
        reg_write(2'd3, `DFC_OFS_ADDR_A, 32'h00abcd);
        reg_check(2'd3, `DFC_OFS_ADDR_A, 32'h00abcd);
        reg_write(2'd0, 5'h04, 32'h5a);
        reg_check(2'd0, 5'h04, 32'h0);
        setup(2'd2, 24'h000100, 16'h2, 32'h119);
        grant_delay <= 4'h3;
        req_primary <= 4'h4;
        item(24'h000100, 1'b1, 1'b1, 8'h04);
        item(24'h000102, 1'b1, 1'b1, 8'h04);
        repeat (4) @(negedge core_clk);
        chk(40'(channel_irq), 40'h4);
        reg_check(2'd2, `DFC_OFS_STATUS, 32'h3);
        @(posedge core_clk);
        req_primary <= 4'h0;
        grant_delay <= 4'h0;
        setup(2'd0, 24'h000020, 16'h1, 32'h01);
        setup(2'd3, 24'h000030, 16'h1, 32'h01);
        req_primary <= 4'h9;
        item(24'h000020, 1'b1, 1'b0, 8'h01);
        item(24'h000030, 1'b1, 1'b0, 8'h08);
        @(posedge core_clk);
        req_primary <= 4'h0;
        setup(2'd2, 24'h000050, 16'h3, 32'hf5);
        req_secondary <= 4'h4;
        item(24'h000050, 1'b0, 1'b0, 8'h40);
        item(24'h00004f, 1'b0, 1'b0, 8'h40);
        chk(40'(gap), 40'h1);
        item(24'h00004e, 1'b0, 1'b0, 8'h40);
        chk(40'(gap), 40'h1);
        @(posedge core_clk);
        req_secondary <= 4'h0;
        debug_halt    <= 1'b1;
        setup(2'd1, 24'h000070, 16'h1, 32'h01);
        req_primary <= 4'h2;
        repeat (20) @(negedge core_clk);
        chk(40'(bus_request), 40'h0);
        @(posedge core_clk);
        debug_halt <= 1'b0;
        item(24'h000070, 1'b1, 1'b0, 8'h02);
        reg_check(2'd1, `DFC_OFS_STATUS, 32'h3);
        setup(2'd1, 24'h000080, 16'h1, 32'h03);
        item(24'h000080, 1'b1, 1'b0, 8'h00);
        tally_and_finish();
    end
endmodule : tb_dfc_transfer_engine
